// file: rtl/timer0_pkg.sv
// Package for the 8-bit timer/counter: register map, field layout, reset values and modes.
// Assumes a plain register port with byte-wide registers at word-index addresses.
package timer0_pkg;

  // Register address indices; the interrupt enable offset is fixed, the others are local choices.
  localparam logic [7:0] ADDR_CONTROL_A = 8'h44;
  localparam logic [7:0] ADDR_CONTROL_B = 8'h45;
  localparam logic [7:0] ADDR_COUNT = 8'h46;
  localparam logic [7:0] ADDR_COMPARE_A = 8'h47;
  localparam logic [7:0] ADDR_COMPARE_B = 8'h48;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h6e;
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h35;

  // Control register B field positions.
  localparam int FORCE_B_BIT = 6;
  localparam int WAVE_BIT2_POS = 3;
  localparam int CLOCK_SEL_LSB = 0;
  // Control register A field positions.
  localparam int OUT_MODE_A_LSB = 6;
  localparam int OUT_MODE_B_LSB = 4;
  localparam int WAVE_LOW_LSB = 0;

  // Interrupt bit positions, shared by enable and flag registers.
  localparam int IRQ_COMPARE_B = 2;
  localparam int IRQ_COMPARE_A = 1;
  localparam int IRQ_OVERFLOW = 0;

  // Writable masks; other bits read as zero.
  localparam logic [7:0] CONTROL_A_MASK = 8'hf3;
  localparam logic [7:0] CONTROL_B_MASK = 8'h0f;
  localparam logic [7:0] IRQ_MASK = 8'h07;

  // Reset values.
  localparam logic [7:0] RESET_VALUE = 8'h00;

  // Counter reference points.
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;

  // Prescaler taps.
  localparam int PRESCALE_WIDTH = 10;
  localparam logic [9:0] DIV8_MASK = 10'h007;
  localparam logic [9:0] DIV64_MASK = 10'h03f;
  localparam logic [9:0] DIV256_MASK = 10'h0ff;
  localparam logic [9:0] DIV1024_MASK = 10'h3ff;

  // Clock select codes.
  typedef enum logic [2:0] {
    CLK_STOP = 3'b000,
    CLK_DIV1 = 3'b001,
    CLK_DIV8 = 3'b010,
    CLK_DIV64 = 3'b011,
    CLK_DIV256 = 3'b100,
    CLK_DIV1024 = 3'b101,
    CLK_EXT_FALL = 3'b110,
    CLK_EXT_RISE = 3'b111
  } clock_select_t;

  // Waveform modes, wave_mode_bit2 then the two low bits.
  typedef enum logic [2:0] {
    WAVE_NORMAL = 3'b000,
    WAVE_PHASE_FF = 3'b001,
    WAVE_CTC = 3'b010,
    WAVE_FAST_FF = 3'b011,
    WAVE_RSVD4 = 3'b100,
    WAVE_PHASE_TOPA = 3'b101,
    WAVE_RSVD6 = 3'b110,
    WAVE_FAST_TOPA = 3'b111
  } wave_mode_t;

  // Register bus request carried as one struct.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } reg_req_t;

  // Timer events produced by the counting core.
  typedef struct packed {
    logic compare_b;
    logic compare_a;
    logic overflow;
  } timer_events_t;

endpackage

// file: rtl/timer0_prescaler.sv
// Shared prescaler: a free-running divider giving one-cycle tick enables.
// Assumes a single io_clock and a synchronised active-low reset.
`timescale 1ns/1ps
module timer0_prescaler #(
  parameter int WIDTH = 10
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  output logic [WIDTH-1:0] count_o
);

  // Refuse widths that cannot reach the divide-by-1024 tap.
  if (WIDTH < timer0_pkg::PRESCALE_WIDTH)
  begin : g_width_check
    $error("Prescaler width too small for divide by 1024.");
  end

  // Divider state.
  logic [WIDTH-1:0] div_reg;
  logic [WIDTH-1:0] div_next;

  // Next divider value wraps naturally.
  assign div_next = div_reg + {{(WIDTH-1){1'b0}}, 1'b1};
  assign count_o = div_reg;

  // Divider runs from reset onward.
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_reg <= '0;
    end
    else
    begin
      div_reg <= div_next;
    end
  end

endmodule

// file: rtl/timer0_regs.sv
// 8-bit timer/counter with control, count, compare and interrupt registers.
// Assumes synchronous register strobes and a global interrupt enable input from the core.
// Also assumes one acknowledge per vector run.
// Functional notes
// - Force compare B only in non-PWM modes.
// - Force drives output B per mode bits.
// - Forced compare sets no flag, no clear.
// - Force bit is strobe, reads zero.
// - Reserved control and interrupt bits read zero.
// - Clock select zero stops the counter.
// - Codes one to five select prescaler taps.
// - Codes six, seven count external falling, rising.
// - External pin counts even when driven out.
// - Counter readable and writable at any time.
// - Counter write blocks next compare match.
// - Both compares checked continuously with counter.
// - Interrupt needs enable, global bit and flag.
// - Compare B flag set, cleared by vector/one.
// - Compare A flag set, cleared by vector/one.
// - Overflow flag set per mode, cleared likewise.
// - Overflow at MAX, BOTTOM or TOP per mode.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
module timer0_regs (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  output logic [7:0] rdata_o,
  input wire logic global_irq_enable_i,
  input wire logic [2:0] vector_ack_i,
  input wire logic external_count_pin_i,
  output logic compare_a_output_pin_o,
  output logic compare_b_output_pin_o,
  output logic [2:0] irq_request_o,
  output logic irq_o
);

  // Reset synchroniser; only the second stage is used.
  // Assert is immediate, release takes two edges.
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;

  // Release the reset through two flip-flops.
  // Both stages clear as soon as the pin drops.
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  // Bus request bundled as a struct.
  // Strobes last one cycle: one action each.
  timer0_pkg::reg_req_t req;
  assign req = '{addr: addr_i, wdata: wdata_i, write: write_i, read: read_i};

  // Registers.
  // Control A: output modes, low wave bits.
  // Control B: force B, wave bit 2, clock select.
  logic [7:0] control_a_reg;
  logic [7:0] control_b_reg;
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic [7:0] compare_a_reg;
  logic [7:0] compare_b_reg;
  logic [7:0] irq_enable_reg;
  logic [7:0] irq_flags_reg;
  logic [7:0] irq_flags_next;
  logic [7:0] rdata_reg;
  logic dir_down_reg;
  logic block_match_reg;
  logic ext_prev_reg;
  logic out_a_reg;
  logic out_b_reg;

  // Address decode.
  // Unmapped indices: writes lost, reads zero.
  wire sel_ctrl_a = req.addr == timer0_pkg::ADDR_CONTROL_A;
  wire sel_ctrl_b = req.addr == timer0_pkg::ADDR_CONTROL_B;
  wire sel_count = req.addr == timer0_pkg::ADDR_COUNT;
  wire sel_cmp_a = req.addr == timer0_pkg::ADDR_COMPARE_A;
  wire sel_cmp_b = req.addr == timer0_pkg::ADDR_COMPARE_B;
  wire sel_irq_en = req.addr == timer0_pkg::ADDR_IRQ_ENABLE;
  wire sel_irq_fl = req.addr == timer0_pkg::ADDR_IRQ_FLAGS;
  wire wr_count = req.write && sel_count;

  // Mode fields.
  // Wave mode is control B bit 3 over A bits 1:0.
  timer0_pkg::wave_mode_t wave_mode;
  timer0_pkg::clock_select_t clk_sel;
  assign wave_mode = timer0_pkg::wave_mode_t'({control_b_reg[timer0_pkg::WAVE_BIT2_POS],
                     control_a_reg[timer0_pkg::WAVE_LOW_LSB +: 2]});
  assign clk_sel = timer0_pkg::clock_select_t'(control_b_reg[timer0_pkg::CLOCK_SEL_LSB +: 3]);
  wire [1:0] out_mode_b = control_a_reg[timer0_pkg::OUT_MODE_B_LSB +: 2];
  wire [1:0] out_mode_a = control_a_reg[timer0_pkg::OUT_MODE_A_LSB +: 2];

  // Mode classes.
  // Reserved wave codes count like normal mode.
  // CTC and compare-A modes take TOP from A.
  wire is_phase = (wave_mode == timer0_pkg::WAVE_PHASE_FF) || (wave_mode == timer0_pkg::WAVE_PHASE_TOPA);
  wire is_fast = (wave_mode == timer0_pkg::WAVE_FAST_FF) || (wave_mode == timer0_pkg::WAVE_FAST_TOPA);
  wire is_ctc = wave_mode == timer0_pkg::WAVE_CTC;
  wire is_pwm = is_phase || is_fast;
  wire top_is_a = is_ctc || (wave_mode == timer0_pkg::WAVE_PHASE_TOPA) ||
                  (wave_mode == timer0_pkg::WAVE_FAST_TOPA);
  wire [7:0] top_value = top_is_a ? compare_a_reg : timer0_pkg::COUNT_MAX;

  // Shared prescaler.
  // It free-runs, so a new tap may fire early once.
  logic [timer0_pkg::PRESCALE_WIDTH-1:0] pre_count;
  timer0_prescaler #(
    .WIDTH(timer0_pkg::PRESCALE_WIDTH)
  ) i_timer0_prescaler (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .count_o(pre_count)
  );

  // Tap is done when all low bits are ones.
  // A tap is one cycle wide.
  function automatic logic tap(input logic [9:0] cnt, input logic [9:0] mask);
    tap = (cnt & mask) == mask;
  endfunction

  // External pin edges; the pin is sampled whatever its direction.
  // Old value resets to the idle low level.
  // Each level must last a cycle to be seen.
  // Pin always observed
  wire ext_rise = external_count_pin_i && !ext_prev_reg;
  wire ext_fall = !external_count_pin_i && ext_prev_reg;

  // Timer clock enable from the selected source.
  // One cycle wide, except code one holds it high; code zero keeps it low.
  logic tick;
  always_comb
  begin
    case (clk_sel)
      timer0_pkg::CLK_STOP: tick = 1'b0;
      timer0_pkg::CLK_DIV1: tick = 1'b1;
      timer0_pkg::CLK_DIV8: tick = tap(pre_count, timer0_pkg::DIV8_MASK);
      timer0_pkg::CLK_DIV64: tick = tap(pre_count, timer0_pkg::DIV64_MASK);
      timer0_pkg::CLK_DIV256: tick = tap(pre_count, timer0_pkg::DIV256_MASK);
      timer0_pkg::CLK_DIV1024: tick = tap(pre_count, timer0_pkg::DIV1024_MASK);
      timer0_pkg::CLK_EXT_FALL: tick = ext_fall;
      timer0_pkg::CLK_EXT_RISE: tick = ext_rise;
      default: tick = 1'b0;
    endcase
  end

  // Matches act only on a timer clock.
  // Continuous compares
  wire match_a_raw = count_reg == compare_a_reg;
  wire match_b_raw = count_reg == compare_b_reg;
  // A counter write blanks the next matches.
  // Blocked after write
  wire match_a = tick && match_a_raw && !block_match_reg;
  wire match_b = tick && match_b_raw && !block_match_reg;

  // Direction turns in phase-correct modes at TOP and BOTTOM.
  // Other modes only count up.
  wire at_top = count_reg == top_value;
  wire at_bottom = count_reg == timer0_pkg::COUNT_BOTTOM;

  // Phase-correct flags at BOTTOM going down,
  // compare-A fast PWM at TOP, others at MAX.
  // Overflow point by mode
  wire overflow_ev = tick && (is_phase ? (dir_down_reg && at_bottom) :
                     (wave_mode == timer0_pkg::WAVE_FAST_TOPA) ? at_top :
                     (count_reg == timer0_pkg::COUNT_MAX));

  // Counter next value; software write wins over counting.
  // A write takes the place of that tick.
  always_comb
  begin
    count_next = count_reg;
    if (wr_count)
    begin
      count_next = req.wdata;
    end
    else if (tick)
    begin
      if (is_phase)
      begin
        count_next = (dir_down_reg ? (at_bottom ? count_reg + 8'h01 : count_reg - 8'h01)
                                   : (at_top ? count_reg - 8'h01 : count_reg + 8'h01));
      end
      else if (at_top)
      begin
        // Only real matches clear in CTC; forcing never reaches here.
        count_next = timer0_pkg::COUNT_BOTTOM;
      end
      else
      begin
        count_next = count_reg + 8'h01;
      end
    end
  end

  // Force strobe, honoured only outside PWM.
  // It touches neither counter nor flags.
  // Non-PWM only
  wire force_b = req.write && sel_ctrl_b && req.wdata[timer0_pkg::FORCE_B_BIT] && !is_pwm;

  // Apply a compare output mode to a pin; non-PWM action.
  // Mode zero keeps the pin as it is.
  function automatic logic apply_mode(input logic [1:0] mode, input logic cur);
    case (mode)
      2'b01: apply_mode = !cur;
      2'b10: apply_mode = 1'b0;
      2'b11: apply_mode = 1'b1;
      default: apply_mode = cur;
    endcase
  endfunction

  // PWM-mode output action at a match; rising count clears when non-inverting.
  // Mode one is reserved and keeps the pin.
  function automatic logic pwm_mode(input logic [1:0] mode, input logic cur, input logic down);
    pwm_mode = mode[1] ? (mode[0] ^ down) : cur;
  endfunction

  // Force beats a match, a match beats TOP.
  // Forced output update
  wire out_b_next = force_b ? apply_mode(out_mode_b, out_b_reg) :
                    match_b ? (is_pwm ? pwm_mode(out_mode_b, out_b_reg, dir_down_reg)
                                      : apply_mode(out_mode_b, out_b_reg)) :
                    (is_fast && tick && at_top && out_mode_b[1]) ? !out_mode_b[0] : out_b_reg;
  wire out_a_next = match_a ? (is_pwm ? pwm_mode(out_mode_a, out_a_reg, dir_down_reg)
                                      : apply_mode(out_mode_a, out_a_reg)) :
                    (is_fast && tick && at_top && out_mode_a[1]) ? !out_mode_a[0] : out_a_reg;

  // Flags: hardware set wins, one clears, zero keeps; forcing never sets.
  // An acknowledge clears only its own flag.
  // No flag on force
  wire [7:0] hw_set = {5'b00000, match_b, match_a, overflow_ev};
  wire [7:0] sw_clear = (req.write && sel_irq_fl) ? req.wdata : 8'h00;
  assign irq_flags_next = ((irq_flags_reg & ~sw_clear & ~{5'b00000, vector_ack_i}) | hw_set)
                          & timer0_pkg::IRQ_MASK;

  // Read multiplexer; reserved and strobe bits read zero.
  // Data stand only in the cycle after the strobe.
  // Zero readback
  wire [7:0] rd_mux = sel_ctrl_a ? (control_a_reg & timer0_pkg::CONTROL_A_MASK) :
                      sel_ctrl_b ? (control_b_reg & timer0_pkg::CONTROL_B_MASK) :
                      sel_count ? count_reg :
                      sel_cmp_a ? compare_a_reg :
                      sel_cmp_b ? compare_b_reg :
                      sel_irq_en ? (irq_enable_reg & timer0_pkg::IRQ_MASK) :
                      sel_irq_fl ? irq_flags_reg : 8'h00;

  // Register file writes: control, compare and interrupt enable.
  // Only software writes these registers.
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      control_a_reg <= timer0_pkg::RESET_VALUE;
      control_b_reg <= timer0_pkg::RESET_VALUE;
      compare_a_reg <= timer0_pkg::RESET_VALUE;
      compare_b_reg <= timer0_pkg::RESET_VALUE;
      irq_enable_reg <= timer0_pkg::RESET_VALUE;
    end
    else if (req.write)
    begin
      if (sel_ctrl_a)
        control_a_reg <= req.wdata & timer0_pkg::CONTROL_A_MASK;
      if (sel_ctrl_b)
        control_b_reg <= req.wdata & timer0_pkg::CONTROL_B_MASK;
      if (sel_cmp_a)
        compare_a_reg <= req.wdata;
      if (sel_cmp_b)
        compare_b_reg <= req.wdata;
      if (sel_irq_en)
        irq_enable_reg <= req.wdata & timer0_pkg::IRQ_MASK;
    end
  end

  // Counter, direction, match block, flags and outputs.
  // Read data return to zero between reads.
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_reg <= timer0_pkg::RESET_VALUE;
      dir_down_reg <= 1'b0;
      block_match_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
      irq_flags_reg <= timer0_pkg::RESET_VALUE;
      out_a_reg <= 1'b0;
      out_b_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end
    else
    begin
      count_reg <= count_next;
      ext_prev_reg <= external_count_pin_i;
      irq_flags_reg <= irq_flags_next;
      out_a_reg <= out_a_next;
      out_b_reg <= out_b_next;
      rdata_reg <= req.read ? rd_mux : 8'h00;
      // Block stays until the next timer clock consumes it.
      // A second write just renews the block.
      if (wr_count)
        block_match_reg <= 1'b1;
      else if (tick)
        block_match_reg <= 1'b0;
      // Direction flips at the ends of a phase-correct sweep.
      // Leaving the mode restarts the sweep upward.
      if (!is_phase)
        dir_down_reg <= 1'b0;
      else if (tick && !wr_count && at_top)
        dir_down_reg <= 1'b1;
      else if (tick && !wr_count && at_bottom)
        dir_down_reg <= 1'b0;
    end
  end

  // Requests follow flags, enables, global bit.
  // Gated requests
  assign irq_request_o = irq_flags_reg[2:0] & irq_enable_reg[2:0] & {3{global_irq_enable_i}};
  assign irq_o = |irq_request_o;
  assign rdata_o = rdata_reg;
  assign compare_a_output_pin_o = out_a_reg;
  assign compare_b_output_pin_o = out_b_reg;

endmodule

// file: testbench/host_vector_model.sv
// Model of the host core's interrupt entry: executes one vector per pending request.
// Assumes the timer clears the matching flag on the clock edge that ends the acknowledge pulse.
`timescale 1ns/1ps
module host_vector_model (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic serve_i,
  input wire logic [2:0] irq_request_i,
  output logic [2:0] vector_ack_o
);
  // Takes the lowest pending request, pulses its acknowledge for one cycle,
  // then leaves a quiet cycle so the flag has time to clear.
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      vector_ack_o <= 3'b000;
    else if (serve_i && vector_ack_o == 3'b000 && irq_request_i != 3'b000)
      vector_ack_o <= irq_request_i & (~irq_request_i + 3'b001);
    else
      vector_ack_o <= 3'b000;
  end
endmodule

// file: testbench/timer0_regs_properties.sv
// Checker for the timer register block, watching only its ports.
// Assumes flag-register writes in the bench happen while the counter is stopped.
`timescale 1ns/1ps
module timer0_regs_properties (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  input wire logic [7:0] rdata_o,
  input wire logic global_irq_enable_i,
  input wire logic [2:0] vector_ack_i,
  input wire logic irq_o,
  input wire logic [2:0] irq_request_o
);
  // Low three write-data bits, the ones that hit flag and enable positions.
  wire logic [2:0] wlow = wdata_i[2:0];
  // Strobes aimed at the flag and enable registers.
  wire logic flag_wr = write_i && (addr_i == timer0_pkg::ADDR_IRQ_FLAGS);
  wire logic en_wr = write_i && (addr_i == timer0_pkg::ADDR_IRQ_ENABLE);
  wire logic irq_rd = read_i && (addr_i == timer0_pkg::ADDR_IRQ_ENABLE || addr_i == timer0_pkg::ADDR_IRQ_FLAGS);

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_irq_line_or: assert property (irq_o == (|irq_request_o))
    else $error("irq line differs from OR of requests");
  a_global_gates_all: assert property (!global_irq_enable_i |-> irq_request_o == 3'b000)
    else $error("request raised with global enable low");
  a_mask_off_quiet: assert property (en_wr && wlow == 3'b000 |=> irq_request_o == 3'b000)
    else $error("request survives cleared enables");
  a_read_data_idle: assert property (!$past(read_i) |-> rdata_o == 8'h00)
    else $error("read data not zero outside read answer");
  a_ctrlb_high_zero: assert property (read_i && addr_i == timer0_pkg::ADDR_CONTROL_B |=> rdata_o[7:4] == 4'h0)
    else $error("control B upper bits read nonzero");
  a_irq_high_zero: assert property (irq_rd |=> rdata_o[7:3] == 5'h00)
    else $error("interrupt register upper bits read nonzero");
  a_vector_clears_flag: assert property ((vector_ack_i & irq_request_o) != 3'b000
    |=> (irq_request_o & $past(vector_ack_i)) == 3'b000)
    else $error("vector acknowledge left flag set");
  a_one_clears_flag: assert property (flag_wr |=> (irq_request_o & $past(wlow)) == 3'b000)
    else $error("write of one left flag set");
  a_zero_keeps_flag: assert property (flag_wr && vector_ack_i == 3'b000
    |=> !global_irq_enable_i || ($past(irq_request_o) & ~$past(wlow) & ~irq_request_o) == 3'b000)
    else $error("write of zero cleared a flag");

  // Main scenarios reached by the bench.
  c_irq_raised: cover property ($rose(irq_o));
  c_vector_taken: cover property (vector_ack_i != 3'b000);
  c_flag_write: cover property (flag_wr);
endmodule

bind timer0_regs timer0_regs_properties i_timer0_regs_properties (
  .ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .write_i(write_i),
  .read_i(read_i),
  .rdata_o(rdata_o),
  .global_irq_enable_i(global_irq_enable_i),
  .vector_ack_i(vector_ack_i),
  .irq_o(irq_o),
  .irq_request_o(irq_request_o)
);

// file: testbench/timer0_regs_tb.sv
// Self-checking bench for the timer register block, driving its register port.
// Assumes the package's register indices and a 40 MHz clock.
`timescale 1ns/1ps
module timer0_regs_tb;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic write_i = 1'b0;
  logic read_i = 1'b0;
  logic global_irq_enable_i = 1'b0;
  logic external_count_pin_i = 1'b0;
  logic serve = 1'b0;
  logic [7:0] rdata_o;
  logic [2:0] vector_ack_i;
  logic compare_a_output_pin_o;
  logic compare_b_output_pin_o;
  logic [2:0] irq_request_o;
  logic irq_o;
  int mismatches = 0;
  int check_count = 0;
  int divs[5] = '{1, 8, 64, 256, 1024};

  // Free-running clock, 25 ns period.
  initial
  begin
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  timer0_regs i_timer0_regs (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
    .global_irq_enable_i(global_irq_enable_i), .vector_ack_i(vector_ack_i),
    .external_count_pin_i(external_count_pin_i), .compare_a_output_pin_o(compare_a_output_pin_o),
    .compare_b_output_pin_o(compare_b_output_pin_o), .irq_request_o(irq_request_o), .irq_o(irq_o)
  );

  host_vector_model i_host_vector_model (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .serve_i(serve),
    .irq_request_i(irq_request_o), .vector_ack_o(vector_ack_i)
  );

  // One-cycle register write.
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    write_i <= 1'b1;
    @(posedge ref_clk_i);
    write_i <= 1'b0;
    // Step past the edge so outputs have settled.
    #1;
  endtask

  // Compares a register value.
  task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Compares an output pin group.
  task automatic check_out(input logic [2:0] got, input logic [2:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle read; data is taken in the answer cycle and compared.
  task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    addr_i <= a;
    read_i <= 1'b1;
    @(posedge ref_clk_i);
    read_i <= 1'b0;
    #1;
    check_reg(rdata_o, exp);
  endtask

  // Runs the counter with a clock select code for exactly n io_clock edges.
  task automatic run_for(input logic [7:0] ctrl, input int n);
    reg_write(timer0_pkg::ADDR_CONTROL_B, ctrl);
    repeat (n - 2) @(posedge ref_clk_i);
    reg_write(timer0_pkg::ADDR_CONTROL_B, 8'h00);
  endtask

  // One full high pulse on the external count pin.
  task automatic pin_pulse();
    @(posedge ref_clk_i) external_count_pin_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    external_count_pin_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
  endtask

  // Prints counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run length.
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    mismatches++;
    give_verdict();
  end

  // Main sequence.
  initial
  begin
    repeat (8) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    expect_reg(timer0_pkg::ADDR_IRQ_ENABLE, 8'h00);
    expect_reg(timer0_pkg::ADDR_CONTROL_B, 8'h00);
    reg_write(timer0_pkg::ADDR_CONTROL_B, 8'hff);
    expect_reg(timer0_pkg::ADDR_CONTROL_B, 8'h0f);
    reg_write(timer0_pkg::ADDR_CONTROL_B, 8'h00);
    reg_write(timer0_pkg::ADDR_IRQ_ENABLE, 8'hff);
    expect_reg(timer0_pkg::ADDR_IRQ_ENABLE, 8'h07);
    reg_write(timer0_pkg::ADDR_IRQ_ENABLE, 8'h00);
    expect_reg(8'h10, 8'h00);
    $display("test reset and reserved bits done");
    reg_write(timer0_pkg::ADDR_COUNT, 8'h5a);
    repeat (20) @(posedge ref_clk_i);
    expect_reg(timer0_pkg::ADDR_COUNT, 8'h5a);
    reg_write(timer0_pkg::ADDR_COMPARE_A, 8'h10);
    reg_write(timer0_pkg::ADDR_COMPARE_B, 8'h20);
    expect_reg(timer0_pkg::ADDR_COMPARE_A, 8'h10);
    expect_reg(timer0_pkg::ADDR_COMPARE_B, 8'h20);
    $display("test stopped counter done");
    for (int i = 0; i < 5; i++)
    begin
      reg_write(timer0_pkg::ADDR_COUNT, 8'h00);
      run_for(8'(i + 1), 3 * divs[i]);
      expect_reg(timer0_pkg::ADDR_COUNT, 8'h03);
    end
    $display("test prescaler taps done");
    reg_write(timer0_pkg::ADDR_COUNT, 8'h00);
    reg_write(timer0_pkg::ADDR_CONTROL_B, 8'h07);
    repeat (3) pin_pulse();
    reg_write(timer0_pkg::ADDR_CONTROL_B, 8'h00);
    expect_reg(timer0_pkg::ADDR_COUNT, 8'h03);
    reg_write(timer0_pkg::ADDR_COUNT, 8'h00);
    reg_write(timer0_pkg::ADDR_CONTROL_B, 8'h06);
    repeat (2) pin_pulse();
    reg_write(timer0_pkg::ADDR_CONTROL_B, 8'h00);
    expect_reg(timer0_pkg::ADDR_COUNT, 8'h02);
    $display("test external pin done");
    reg_write(timer0_pkg::ADDR_IRQ_FLAGS, 8'h07);
    expect_reg(timer0_pkg::ADDR_IRQ_FLAGS, 8'h00);
    @(posedge ref_clk_i) global_irq_enable_i <= 1'b1;
    reg_write(timer0_pkg::ADDR_IRQ_ENABLE, 8'h07);
    reg_write(timer0_pkg::ADDR_CONTROL_A, 8'h40);
    reg_write(timer0_pkg::ADDR_COUNT, 8'h00);
    run_for(8'h01, 40);
    expect_reg(timer0_pkg::ADDR_IRQ_FLAGS, 8'h06);
    check_out(irq_request_o, 3'b110);
    check_out({2'b00, irq_o}, 3'b001);
    check_out({2'b00, compare_a_output_pin_o}, 3'b001);
    reg_write(timer0_pkg::ADDR_IRQ_ENABLE, 8'h00);
    check_out(irq_request_o, 3'b000);
    reg_write(timer0_pkg::ADDR_IRQ_ENABLE, 8'h02);
    check_out(irq_request_o, 3'b010);
    reg_write(timer0_pkg::ADDR_IRQ_FLAGS, 8'h00);
    expect_reg(timer0_pkg::ADDR_IRQ_FLAGS, 8'h06);
    reg_write(timer0_pkg::ADDR_IRQ_FLAGS, 8'h02);
    expect_reg(timer0_pkg::ADDR_IRQ_FLAGS, 8'h04);
    reg_write(timer0_pkg::ADDR_IRQ_ENABLE, 8'h04);
    @(posedge ref_clk_i) serve <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    serve <= 1'b0;
    expect_reg(timer0_pkg::ADDR_IRQ_FLAGS, 8'h00);
    reg_write(timer0_pkg::ADDR_COUNT, 8'hf0);
    reg_write(timer0_pkg::ADDR_IRQ_ENABLE, 8'h01);
    run_for(8'h01, 30);
    expect_reg(timer0_pkg::ADDR_IRQ_FLAGS, 8'h01);
    check_out(irq_request_o, 3'b001);
    @(posedge ref_clk_i) global_irq_enable_i <= 1'b0;
    @(posedge ref_clk_i) #1;
    check_out(irq_request_o, 3'b000);
    @(posedge ref_clk_i);
    global_irq_enable_i <= 1'b1;
    serve <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    serve <= 1'b0;
    expect_reg(timer0_pkg::ADDR_IRQ_FLAGS, 8'h00);
    reg_write(timer0_pkg::ADDR_COUNT, 8'h10);
    run_for(8'h01, 3);
    expect_reg(timer0_pkg::ADDR_IRQ_FLAGS, 8'h00);
    check_out({2'b00, compare_a_output_pin_o}, 3'b001);
    $display("test interrupts done");
    reg_write(timer0_pkg::ADDR_IRQ_ENABLE, 8'h00);
    reg_write(timer0_pkg::ADDR_CONTROL_A, 8'h12);
    reg_write(timer0_pkg::ADDR_COUNT, 8'h05);
    reg_write(timer0_pkg::ADDR_CONTROL_B, 8'h40);
    repeat (2) @(posedge ref_clk_i);
    check_out({2'b00, compare_b_output_pin_o}, 3'b001);
    expect_reg(timer0_pkg::ADDR_IRQ_FLAGS, 8'h00);
    expect_reg(timer0_pkg::ADDR_COUNT, 8'h05);
    expect_reg(timer0_pkg::ADDR_CONTROL_B, 8'h00);
    reg_write(timer0_pkg::ADDR_CONTROL_A, 8'h23);
    reg_write(timer0_pkg::ADDR_CONTROL_B, 8'h40);
    repeat (2) @(posedge ref_clk_i);
    check_out({2'b00, compare_b_output_pin_o}, 3'b001);
    reg_write(timer0_pkg::ADDR_CONTROL_B, 8'h00);
    reg_write(timer0_pkg::ADDR_CONTROL_A, 8'h20);
    reg_write(timer0_pkg::ADDR_CONTROL_B, 8'h40);
    repeat (2) @(posedge ref_clk_i);
    check_out({2'b00, compare_b_output_pin_o}, 3'b000);
    $display("test force compare done");
    reg_write(timer0_pkg::ADDR_CONTROL_A, 8'h01);
    reg_write(timer0_pkg::ADDR_COUNT, 8'hfe);
    run_for(8'h01, 257);
    expect_reg(timer0_pkg::ADDR_COUNT, 8'h01);
    expect_reg(timer0_pkg::ADDR_IRQ_FLAGS, 8'h07);
    $display("test phase correct done");
    give_verdict();
  end
endmodule
